/* pkg/pbs_burst_if.sv */
// Carrier between the access control and the burst counter
interface pbs_burst_if;
    logic                       load;
    logic                       step;
    logic                       order;
    logic [pbs_pkg::CNT_W-1:0]  start;
    logic [pbs_pkg::CNT_W-1:0]  low;

    modport ctl (
        output load,
        output step,
        output order,
        output start,
        input  low
    );

    modport ctr (
        input  load,
        input  step,
        input  order,
        input  start,
        output low
    );
endinterface

/* pkg/pbs_pkg.sv */
// Shared constants and types for the pipelined burst memory
package pbs_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W  = 18;
    localparam int LANE_W  = 9;
    localparam int LANES   = 2;
    localparam int DATA_W  = LANE_W * LANES;
    localparam int CNT_W   = 2;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0]  CNT_RST    = 2'h0;
    localparam logic [LANES-1:0]  LANES_IDLE = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST   = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 18'h00000;
    localparam logic [1:0]        SYNC_RST   = 2'h0;

    // ------------------------------------------------------------
    // Burst tracking state
    // ------------------------------------------------------------
    typedef enum logic {
        PBS_ST_IDLE  = 1'b0,
        PBS_ST_BURST = 1'b1
    } pbs_state_e;

endpackage

/* src/pbs_burst_ctr.sv */
// Two-bit burst counter with linear or interleaved ordering
module pbs_burst_ctr (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    pbs_burst_if.ctr    bif
);

    // ------------------------------------------------------------
    // Counter and start capture
    // ------------------------------------------------------------
    logic [pbs_pkg::CNT_W-1:0] cnt_q;
    logic [pbs_pkg::CNT_W-1:0] cnt_d;
    logic [pbs_pkg::CNT_W-1:0] start_q;
    logic [pbs_pkg::CNT_W-1:0] start_d;
    logic [pbs_pkg::CNT_W-1:0] lin_low;
    logic [pbs_pkg::CNT_W-1:0] ilv_low;
    logic [pbs_pkg::CNT_W-1:0] seq_low;

    // Load clears the count; step advances it one place
    assign cnt_d   = bif.load ? pbs_pkg::CNT_RST
                   : bif.step ? cnt_q + 2'h1
                   : cnt_q;
    assign start_d = bif.load ? bif.start : start_q;

    // Wraps modulo four by width of the sum
    assign lin_low = start_d + cnt_d;
    assign ilv_low = start_d ^ cnt_d;
    assign seq_low = bif.order ? ilv_low : lin_low;
    assign bif.low = seq_low;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= pbs_pkg::CNT_RST;
            start_q <= pbs_pkg::CNT_RST;
        end else begin
            cnt_q   <= cnt_d;
            start_q <= start_d;
        end
    end

endmodule // pbs_burst_ctr

/* src/pbs_sram.sv */
// Pipelined synchronous burst memory, 256K words of two 9-bit lanes
//
// Overview of operation
// - 256K words, 18 bits, two lanes
// - Two-bit counter supplies low burst address
// - Address, data, controls registered on rising edge, except burst order select and output drive enable
// - Either address strobe starts a burst
// - Later addresses internal, step only on burst_step
// - Burst order select picks linear or interleaved
// - Writes start at edge, self-timed internally
// - Each lane write enable governs its lane
// - Write qualifier stores only enabled lanes
// - Global write, or qualifier plus all, stores both
// - Read data through output register, one stage
// - Strobe aborts burst, latches new address
// - Chip select high: ignore processor, deselect controller
// - Output drive enable asynchronous, low drives lanes
module pbs_sram #(
    parameter int ADDR_W = pbs_pkg::ADDR_W,
    parameter int LANE_W = pbs_pkg::LANE_W,
    parameter int LANES  = pbs_pkg::LANES
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rstn,
    input  wire logic [ADDR_W-1:0]         address_inputs,
    input  wire logic [LANE_W*LANES-1:0]   data_lanes_in,
    output logic [LANE_W*LANES-1:0]        data_lanes_out,
    output logic [LANES-1:0]               data_lanes_oe,
    input  wire logic                      processor_address_strobe_n,
    input  wire logic                      controller_address_strobe_n,
    input  wire logic                      burst_step_n,
    input  wire logic [LANES-1:0]          byte_write_enables_n,
    input  wire logic                      global_write_n,
    input  wire logic                      write_qualifier_n,
    input  wire logic                      primary_chip_select_n,
    input  wire logic                      burst_order_select,
    input  wire logic                      output_drive_en_n
);

    localparam int DATA_W = LANE_W * LANES;
    localparam int DEPTH  = 1 << ADDR_W;
    localparam int CW     = pbs_pkg::CNT_W;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= pbs_pkg::SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------
    // Far end is logic on this clock: one non-inverting stage only
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic              pstb_n_q;
    logic              cstb_n_q;
    logic              step_n_q;
    logic [LANES-1:0]  bwe_n_q;
    logic              gw_n_q;
    logic              wq_n_q;
    logic              cs_n_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_q   <= pbs_pkg::ADDR_RST;
            wdata_q  <= pbs_pkg::DATA_RST;
            pstb_n_q <= 1'b1;
            cstb_n_q <= 1'b1;
            step_n_q <= 1'b1;
            bwe_n_q  <= pbs_pkg::LANES_IDLE;
            gw_n_q   <= 1'b1;
            wq_n_q   <= 1'b1;
            cs_n_q   <= 1'b1;
        end else begin
            addr_q   <= address_inputs;
            wdata_q  <= data_lanes_in;
            pstb_n_q <= processor_address_strobe_n;
            cstb_n_q <= controller_address_strobe_n;
            step_n_q <= burst_step_n;
            bwe_n_q  <= byte_write_enables_n;
            gw_n_q   <= global_write_n;
            wq_n_q   <= write_qualifier_n;
            cs_n_q   <= primary_chip_select_n;
        end
    end

    // ------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------
    pbs_pkg::pbs_state_e state_q;
    pbs_pkg::pbs_state_e state_d;
    logic [ADDR_W-CW-1:0] base_q;
    logic [ADDR_W-CW-1:0] base_d;
    logic                 pstb_take;
    logic                 cstb_take;
    logic                 new_burst;
    logic                 deselect;
    logic                 in_burst;
    logic                 access;
    logic                 step_go;
    logic [ADDR_W-1:0]    acc_addr;
    logic [LANES-1:0]     lane_wr;
    logic                 any_wr;
    logic                 rd_go;

    // Processor strobe is blocked while chip select is high
    assign pstb_take = !pstb_n_q && !cs_n_q;
    assign cstb_take = !cstb_n_q;
    assign new_burst = pstb_take || (cstb_take && !cs_n_q);
    assign deselect  = !pstb_take && cstb_take && cs_n_q;
    assign in_burst  = state_q == pbs_pkg::PBS_ST_BURST;
    // Strobe wins over any burst in progress
    assign step_go   = in_burst && !new_burst && !deselect
                     && !step_n_q;
    assign access    = new_burst || (in_burst && !deselect);

    always_comb begin
        state_d = state_q;
        case (state_q)
            pbs_pkg::PBS_ST_IDLE: begin
                if (new_burst) begin
                    state_d = pbs_pkg::PBS_ST_BURST;
                end
            end
            pbs_pkg::PBS_ST_BURST: begin
                if (deselect) begin
                    state_d = pbs_pkg::PBS_ST_IDLE;
                end
            end
            default: begin
                state_d = pbs_pkg::PBS_ST_IDLE;
            end
        endcase
    end

    assign base_d = new_burst ? addr_q[ADDR_W-1:CW] : base_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pbs_pkg::PBS_ST_IDLE;
            base_q  <= '0;
        end else begin
            state_q <= state_d;
            base_q  <= base_d;
        end
    end

    // ------------------------------------------------------------
    // Burst counter
    // ------------------------------------------------------------
    pbs_burst_if bif ();

    assign bif.load  = new_burst;
    assign bif.step  = step_go;
    // Static strap, read straight from the pin
    assign bif.order = burst_order_select;
    assign bif.start = addr_q[CW-1:0];

    pbs_burst_ctr u_ctr (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .bif     (bif)
    );

    // High bits stay fixed; burst wraps inside four words
    assign acc_addr = {base_d, bif.low};

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_wdec
            assign lane_wr[gi] = access
                && (!gw_n_q
                    || (!wq_n_q && !bwe_n_q[gi]));
        end
    endgenerate

    assign any_wr = |lane_wr;
    // A lane-less write cycle still counts as a write, no read
    assign rd_go  = access && gw_n_q && wq_n_q;

    // ------------------------------------------------------------
    // Array and output register
    // ------------------------------------------------------------
    logic              rd_valid_q;
    logic [DATA_W-1:0] rd_q;

    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            logic [LANE_W-1:0] mem [DEPTH];

            // Storage has no reset: contents undefined at power up
            always_ff @(posedge clk_sys) begin
                if (lane_wr[gi]) begin
                    mem[acc_addr] <=
                        wdata_q[gi*LANE_W +: LANE_W];
                end
            end

            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    rd_q[gi*LANE_W +: LANE_W] <= '0;
                end else if (rd_go) begin
                    rd_q[gi*LANE_W +: LANE_W] <= mem[acc_addr];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_go && !any_wr;
        end
    end

    // ------------------------------------------------------------
    // Lane drivers
    // ------------------------------------------------------------
    assign data_lanes_out = rd_q;

    // Enable is combinational on purpose: the pin acts unclocked
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_oe
            assign data_lanes_oe[gi] =
                rd_valid_q && !output_drive_en_n;
        end
    endgenerate

endmodule // pbs_sram

/* verif/pbs_host.sv */
// Far-side controller model driving burst cycles onto the pins
module pbs_host (
    output logic [pbs_pkg::ADDR_W-1:0] address_inputs,
    output logic [pbs_pkg::DATA_W-1:0] data_lanes_in,
    output logic                       processor_address_strobe_n,
    output logic                       controller_address_strobe_n,
    output logic                       burst_step_n,
    output logic [pbs_pkg::LANES-1:0]  byte_write_enables_n,
    output logic                       global_write_n,
    output logic                       write_qualifier_n,
    output logic                       primary_chip_select_n,
    output logic                       burst_order_select,
    output logic                       output_drive_en_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        data_lanes_in = '0;
        drive(1, 1, 1, 1, 2'h3, 1, 1, '0, '0, 0);
        set_oe(1'b0);
    end

    // Drive enable is unclocked, so it may move in any cycle
    task automatic set_oe(input logic v);
        output_drive_en_n = v;
    endtask

    // Called just after a falling edge, held a full cycle
    task automatic drive(input logic ap, ac, cs, st, input logic [1:0] bw,
                         input logic gw, wq,
                         input logic [pbs_pkg::ADDR_W-1:0] a,
                         input logic [pbs_pkg::DATA_W-1:0] d,
                         input logic ord);
        processor_address_strobe_n  = ap;
        controller_address_strobe_n = ac;
        primary_chip_select_n       = cs;
        burst_step_n                = st;
        byte_write_enables_n        = bw;
        global_write_n              = gw;
        write_qualifier_n           = wq;
        address_inputs              = a;
        burst_order_select          = ord;
        // No stale data outside writes
        data_lanes_in = (gw && wq) ? ~data_lanes_in : d;
    endtask
endmodule // pbs_host

/* verif/pbs_sram_chk.sv */
// Pin-level assertions for the pipelined burst memory
module pbs_sram_chk #(
    parameter int LANE_W = 9,
    parameter int LANES  = 2
) (
    input wire logic                    clk_sys,
    input wire logic                    rstn,
    input wire logic [LANE_W*LANES-1:0] data_lanes_out,
    input wire logic [LANES-1:0]        data_lanes_oe,
    input wire logic                    processor_address_strobe_n,
    input wire logic                    controller_address_strobe_n,
    input wire logic [LANES-1:0]        byte_write_enables_n,
    input wire logic                    global_write_n,
    input wire logic                    write_qualifier_n,
    input wire logic                    primary_chip_select_n,
    input wire logic                    output_drive_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Decode of sampled controls
    // ----------------------------------------
    wire logic nw = !primary_chip_select_n &&
        (!processor_address_strobe_n || !controller_address_strobe_n);
    wire logic rd = nw && global_write_n && write_qualifier_n;
    wire logic ds = !controller_address_strobe_n && primary_chip_select_n;
    wire logic [LANES-1:0] on = {LANES{1'b1}};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    sequence s_wr; nw && !global_write_n; endsequence
    sequence s_void;
        nw && global_write_n && !write_qualifier_n &&
        byte_write_enables_n == on;
    endsequence
    sequence s_quiet; !nw && controller_address_strobe_n; endsequence

    property p_oe_async; output_drive_en_n |-> data_lanes_oe == '0;
    endproperty
    property p_rd_oe; rd ##2 !output_drive_en_n |-> data_lanes_oe == on;
    endproperty
    property p_wr_oe; s_wr |-> ##2 data_lanes_oe == '0; endproperty
    property p_wr_hold; s_wr |-> ##2 $stable(data_lanes_out); endproperty
    property p_void;
        s_void |-> ##2 data_lanes_oe == '0 && $stable(data_lanes_out);
    endproperty
    property p_desel; ds |-> ##2 data_lanes_oe == '0; endproperty
    property p_idle;
        ds ##1 s_quiet [*2] |=>
            data_lanes_oe == '0 && $stable(data_lanes_out);
    endproperty
    // Changes only through a read, never on its own
    property p_change;
        !$stable(data_lanes_out) && !output_drive_en_n |->
            data_lanes_oe == on;
    endproperty

    a_oe_async: assert property (p_oe_async)
        else $error("lanes driven while drive enable high");
    a_rd_oe: assert property (p_rd_oe)
        else $error("read not presented after one stage");
    a_wr_oe: assert property (p_wr_oe)
        else $error("write cycle drove the lanes");
    a_wr_hold: assert property (p_wr_hold)
        else $error("write cycle changed read data");
    a_void: assert property (p_void)
        else $error("write with no lane acted");
    a_desel: assert property (p_desel)
        else $error("deselect drove the lanes");
    a_idle: assert property (p_idle)
        else $error("idle cycle acted without strobe");
    a_change: assert property (p_change)
        else $error("read data changed without read");
endmodule // pbs_sram_chk

bind pbs_sram pbs_sram_chk #(.LANE_W(LANE_W), .LANES(LANES)) u_chk (
    .clk_sys, .rstn, .data_lanes_out, .data_lanes_oe,
    .processor_address_strobe_n, .controller_address_strobe_n,
    .byte_write_enables_n, .global_write_n, .write_qualifier_n,
    .primary_chip_select_n, .output_drive_en_n
);

/* verif/tb_pbs_sram.sv */
// Self-checking bench for the pipelined burst memory
module tb_pbs_sram;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Pins and model state
    // ----------------------------------------
    logic                       clk_sys;
    logic                       rstn;
    wire [pbs_pkg::ADDR_W-1:0]  address_inputs;
    wire [pbs_pkg::DATA_W-1:0]  data_lanes_in, data_lanes_out;
    wire [pbs_pkg::LANES-1:0]   data_lanes_oe, byte_write_enables_n;
    wire processor_address_strobe_n, controller_address_strobe_n;
    wire burst_step_n, global_write_n, write_qualifier_n;
    wire primary_chip_select_n, burst_order_select, output_drive_en_n;
    logic [pbs_pkg::DATA_W-1:0] mem [int];
    logic [pbs_pkg::DATA_W-1:0] qd [$];
    logic [pbs_pkg::DATA_W-1:0] last = '0;
    bit                         qv [$];
    int                         base, cnt, err_count, n_checks, ba, bb;
    bit                         act, ord, oen;

    pbs_sram DUT (
        .clk_sys, .rstn, .address_inputs, .data_lanes_in, .data_lanes_out,
        .data_lanes_oe, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_step_n, .byte_write_enables_n,
        .global_write_n, .write_qualifier_n, .primary_chip_select_n,
        .burst_order_select, .output_drive_en_n
    );
    pbs_host u_host (
        .address_inputs, .data_lanes_in, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_step_n, .byte_write_enables_n,
        .global_write_n, .write_qualifier_n, .primary_chip_select_n,
        .burst_order_select, .output_drive_en_n
    );
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(logic [pbs_pkg::DATA_W-1:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    function automatic logic [pbs_pkg::DATA_W-1:0] rnd();
        bit [31:0] r;
        r = $urandom;
        return r[17:0];
    endfunction

    // One cycle: check the op two back, model and drive this one
    task automatic op(bit ap, ac, cs, st, bit [1:0] bw, bit gw, wq,
                      int a = 0, logic [pbs_pkg::DATA_W-1:0] d = '0);
        int ad;
        bit rv;
        bit [1:0] ln;
        @(negedge clk_sys);
        u_host.set_oe(oen);
        #1;
        if (qv.size() >= 2) begin
            rv = qv.pop_front();
            chk(18'(data_lanes_oe), 18'({2{rv && !oen}}));
            chk(data_lanes_out, qd.pop_front());
        end
        if (!cs && (!ap || !ac)) begin
            base = a;
            cnt = 0;
            act = 1;
        end else if (!ac && cs) act = 0;
        else if (act && !st) cnt = (cnt + 1) % 4;
        ad = (base & ~3) | ((ord ? base ^ cnt : base + cnt) & 3);
        rv = 0;
        ln = gw ? ~bw & {2{!wq}} : 2'h3;
        if (act && gw && wq) begin
            rv = 1;
            last = mem[ad];
        end else if (act) begin
            if (ln[0]) mem[ad][8:0] = d[8:0];
            if (ln[1]) mem[ad][17:9] = d[17:9];
        end
        qv.push_back(rv);
        qd.push_back(last);
        u_host.drive(ap, ac, cs, st, bw, gw, wq, a[17:0], d, ord);
    endtask

    task automatic rd(int a);
        op(1, 0, 0, 1, 2'h3, 1, 1, a);
    endtask
    task automatic nx(bit st, bit gw = 1);
        op(1, 1, 0, st, 2'h3, gw, 1, $urandom, rnd());
    endtask
    task automatic ds();
        op(1, 0, 1, 1, 2'h3, 1, 1);
    endtask
    task automatic fill(int a);
        op(1, 0, 0, 1, 2'h3, 0, 1, a, rnd());
        repeat (3) nx(0, 0);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("[ERR] %0t run did not finish", $time);
        report_and_stop();
    end

    initial begin
        rstn = 1'b0;
        void'($urandom(66));
        repeat (20) @(posedge clk_sys);
        chk(data_lanes_out, '0);
        @(negedge clk_sys);
        rstn = 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int o = 0; o < 2; o++) begin
            for (int s = 0; s < 4; s++) begin
                ord = o[0]; // changed only while deselected
                ba = $urandom & 32'h3FFFC;
                fill(ba);
                rd(ba + s);
                for (int i = 0; i < 4; i++) nx(i == 1);
                ds();
                ds();
            end
        end
        $display("burst order test done");
        for (int k = 0; k < 4; k++) begin
            ba = $urandom & 32'h3FFFC;
            op(1, 0, 0, 1, 2'h3, 0, 1, ba, rnd());
            op(1, 0, 0, 1, k[1:0], 1, 0, ba, rnd());
            op(0, 1, 0, 1, k[1:0], 0, k[0], ba + 1, rnd());
            rd(ba);
            nx(0);
            ds();
            ds();
        end
        $display("byte lane test done");
        ba = $urandom & 32'h3FFFC;
        bb = $urandom & 32'h3FFFC;
        fill(ba);
        fill(bb);
        rd(ba);
        nx(0);
        op(0, 1, 0, 1, 2'h3, 1, 1, bb);
        nx(0);
        op(0, 1, 1, 0, 2'h3, 1, 1, ba);
        ds();
        op(0, 1, 1, 1, 2'h3, 1, 1, ba);
        op(1, 1, 0, 0, 2'h3, 1, 1);
        rd(bb + 2);
        ds();
        ds();
        $display("strobe test done");
        repeat (12) begin
            oen = $urandom % 2;
            rd(ba + $urandom % 4);
        end
        oen = 0;
        ds();
        ds();
        ds();
        $display("drive enable test done");
        report_and_stop();
    end
endmodule // tb_pbs_sram
